/* File: trcc_regs.sv */
// How it works
// RULE1: threshold four at 0x22, reset 7112
// RULE2: threshold five at 0x23, reset 6325
// RULE3: threshold six at 0x24, reset 4970
// RULE4: readings fall with heat; colder thresholds larger
// RULE5: 0x25 bits 9:5 region six voltage, 19
// RULE6: 0x25 bits 4:0 region five voltage, 23
// RULE7: 0x26 bits 14:10 region four voltage, 23
// RULE8: 0x26 bits 9:5 region three voltage, 31
// RULE9: 0x26 bits 4:0 region two voltage, 31
// RULE10: voltage codes share the base voltage encoding
// RULE11: 0x27 bits 9:5 region six current, 15
// RULE12: 0x27 bits 4:0 region five current, 15
// RULE13: current codes share the base current encoding
// RULE14: 0x28 fifteen-bit current codes, reset 32751
// RULE15: 0x28 fields regions four, three, two
// RULE16: region codes apply only while enable set
// RULE17: pick region from reading, present its codes
// RULE18: bits above each field read zero
`timescale 1ns/1ps
module trcc_regs
    import trcc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic temp_qual_en,
    input wire logic [15:0] thermistor_reading,
    input wire logic [15:0] temp_threshold_one,
    input wire logic [15:0] temp_threshold_two,
    input wire logic [15:0] temp_threshold_three,
    input wire logic [4:0] base_volt_code,
    input wire logic [4:0] base_curr_code,
    output logic [2:0] temp_region,
    output logic [4:0] region_volt_code,
    output logic [4:0] region_curr_code
);

    // Line events from the pin sampler.
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_val;

    // Serial engine state and its next values.
    trcc_state_e state_r, state_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt; // Bits of the current byte.
    logic got8_r, got8_nxt; // Eighth bit has been clocked.
    logic [7:0] shift_r, shift_nxt; // Incoming byte.
    logic [7:0] tx_r, tx_nxt; // Outgoing byte, msb first.
    logic rw_r, rw_nxt; // Read requested in the address byte.
    logic [7:0] cmd_r, cmd_nxt; // Command code of the transfer.
    logic idx_r, idx_nxt; // High byte of the word in progress.
    logic [7:0] low_r, low_nxt; // Low byte of a write word.
    logic [15:0] hold_r, hold_nxt; // Read word captured at its start.
    logic host_ack_r, host_ack_nxt; // Host acked the last read byte.
    logic oe_r, oe_nxt; // Pull the data line low.
    logic wr_pulse; // A whole write word has arrived.

    // Register contents.
    logic [15:0] thr_four_r;
    logic [15:0] thr_five_r;
    logic [15:0] thr_six_r;
    logic [9:0] volt_warm_r;
    logic [14:0] volt_mid_r;
    logic [9:0] curr_warm_r;
    logic [14:0] curr_mid_r;

    // Write decode and read selection.
    logic [15:0] wr_data;
    logic wr_thr_four;
    logic wr_thr_five;
    logic wr_thr_six;
    logic wr_volt_warm;
    logic wr_volt_mid;
    logic wr_curr_warm;
    logic wr_curr_mid;
    logic [15:0] rd_word;
    logic addr_hit;

    trcc_pin_events u_pins (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det),
        .sda_val(sda_val)
    );

    // Words travel low byte first, as on a word-wide serial write.
    assign wr_data = {shift_r, low_r};
    assign addr_hit = shift_r[7:1] == DEV_ADDR;
    assign wr_thr_four = wr_pulse && cmd_r == CMD_THR_FOUR;
    assign wr_thr_five = wr_pulse && cmd_r == CMD_THR_FIVE;
    assign wr_thr_six = wr_pulse && cmd_r == CMD_THR_SIX;
    assign wr_volt_warm = wr_pulse && cmd_r == CMD_VOLT_WARM;
    assign wr_volt_mid = wr_pulse && cmd_r == CMD_VOLT_MID;
    assign wr_curr_warm = wr_pulse && cmd_r == CMD_CURR_WARM;
    assign wr_curr_mid = wr_pulse && cmd_r == CMD_CURR_MID;

    // Narrow registers are zero-extended; other commands read as zero.
    assign rd_word =
        (cmd_r == CMD_THR_FOUR) ? thr_four_r :
        (cmd_r == CMD_THR_FIVE) ? thr_five_r :
        (cmd_r == CMD_THR_SIX) ? thr_six_r :
        (cmd_r == CMD_VOLT_WARM) ? {6'h00, volt_warm_r} : // [RULE18]
        (cmd_r == CMD_VOLT_MID) ? {1'b0, volt_mid_r} :
        (cmd_r == CMD_CURR_WARM) ? {6'h00, curr_warm_r} :
        (cmd_r == CMD_CURR_MID) ? {1'b0, curr_mid_r} : 16'h0000;

    // The line is open drain: we only ever pull it low.
    assign sda_out = 1'b0;
    assign sda_oe = oe_r;

    // Serial engine. Data is taken on a clock rise and changed on a
    // clock fall, so our drive never moves while the clock is high.
    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        got8_nxt = got8_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        rw_nxt = rw_r;
        cmd_nxt = cmd_r;
        idx_nxt = idx_r;
        low_nxt = low_r;
        hold_nxt = hold_r;
        host_ack_nxt = host_ack_r;
        oe_nxt = oe_r;
        wr_pulse = 1'b0;
        if (stop_det) begin
            // A stop abandons any half word; nothing is written.
            state_nxt = S_IDLE;
            oe_nxt = 1'b0;
        end else if (start_det) begin
            // Start or repeated start; the command code is kept.
            state_nxt = S_ADDR;
            bit_cnt_nxt = 3'h0;
            got8_nxt = 1'b0;
            oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    oe_nxt = 1'b0;
                end
                S_ADDR, S_CMD, S_WR: begin
                    if (scl_rise && !got8_r) begin
                        shift_nxt = {shift_r[6:0], sda_val};
                        bit_cnt_nxt = bit_cnt_r + 3'h1;
                        got8_nxt = bit_cnt_r == 3'h7;
                    end else if (scl_fall && got8_r) begin
                        got8_nxt = 1'b0;
                        bit_cnt_nxt = 3'h0;
                        oe_nxt = 1'b1;
                        if (state_r == S_ADDR) begin
                            // A foreign address gets no ack.
                            rw_nxt = shift_r[0];
                            oe_nxt = addr_hit;
                            state_nxt = addr_hit ? S_AACK : S_IDLE;
                        end else if (state_r == S_CMD) begin
                            cmd_nxt = shift_r;
                            idx_nxt = 1'b0;
                            state_nxt = S_CACK;
                        end else begin
                            low_nxt = idx_r ? low_r : shift_r;
                            wr_pulse = idx_r;
                            state_nxt = S_WACK;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            // Capture the word so both bytes agree.
                            hold_nxt = rd_word;
                            tx_nxt = rd_word[7:0];
                            oe_nxt = ~rd_word[7];
                            idx_nxt = 1'b0;
                            state_nxt = S_RD;
                        end else begin
                            oe_nxt = 1'b0;
                            state_nxt = S_CMD;
                        end
                    end
                end
                S_CACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        state_nxt = S_WR;
                    end
                end
                S_WACK: begin
                    // Bytes past the word are not acked.
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        idx_nxt = 1'b1;
                        state_nxt = idx_r ? S_IDLE : S_WR;
                    end
                end
                S_RD: begin
                    if (scl_rise) begin
                        bit_cnt_nxt = bit_cnt_r + 3'h1;
                        got8_nxt = bit_cnt_r == 3'h7;
                    end else if (scl_fall) begin
                        if (got8_r) begin
                            got8_nxt = 1'b0;
                            bit_cnt_nxt = 3'h0;
                            oe_nxt = 1'b0;
                            state_nxt = S_RACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            oe_nxt = ~tx_r[6];
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        host_ack_nxt = ~sda_val;
                    end else if (scl_fall) begin
                        if (host_ack_r && !idx_r) begin
                            idx_nxt = 1'b1;
                            tx_nxt = hold_r[15:8];
                            oe_nxt = ~hold_r[15];
                            state_nxt = S_RD;
                        end else begin
                            state_nxt = S_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt = S_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // Engine flip-flops.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
            bit_cnt_r <= 3'h0;
            got8_r <= 1'b0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            cmd_r <= 8'h00;
            idx_r <= 1'b0;
            low_r <= 8'h00;
            hold_r <= 16'h0000;
            host_ack_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            got8_r <= got8_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            rw_r <= rw_nxt;
            cmd_r <= cmd_nxt;
            idx_r <= idx_nxt;
            low_r <= low_nxt;
            hold_r <= hold_nxt;
            host_ack_r <= host_ack_nxt;
            oe_r <= oe_nxt;
        end
    end

    // Register bank; bits above each field are never stored.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            thr_four_r <= THR_FOUR_RST; // [RULE1]
            thr_five_r <= THR_FIVE_RST; // [RULE2]
            thr_six_r <= THR_SIX_RST; // [RULE3]
            volt_warm_r <= VOLT_WARM_RST; // [RULE5] [RULE6]
            volt_mid_r <= VOLT_MID_RST; // [RULE7] [RULE8] [RULE9]
            curr_warm_r <= CURR_WARM_RST; // [RULE11] [RULE12]
            curr_mid_r <= CURR_MID_RST; // [RULE14] [RULE15]
        end else begin
            if (wr_thr_four) thr_four_r <= wr_data; // [RULE1]
            if (wr_thr_five) thr_five_r <= wr_data; // [RULE2]
            if (wr_thr_six) thr_six_r <= wr_data; // [RULE3]
            if (wr_volt_warm) volt_warm_r <= wr_data[PAIR_W-1:0]; // [RULE18]
            if (wr_volt_mid) volt_mid_r <= wr_data[TRIO_W-1:0]; // [RULE7] [RULE8] [RULE9]
            if (wr_curr_warm) curr_warm_r <= wr_data[PAIR_W-1:0];
            if (wr_curr_mid) curr_mid_r <= wr_data[TRIO_W-1:0];
        end
    end

    trcc_region_sel u_region (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .temp_qual_en(temp_qual_en),
        .thermistor_reading(thermistor_reading),
        .temp_threshold_one(temp_threshold_one),
        .temp_threshold_two(temp_threshold_two),
        .temp_threshold_three(temp_threshold_three),
        .temp_threshold_four(thr_four_r),
        .temp_threshold_five(thr_five_r),
        .temp_threshold_six(thr_six_r),
        .volt_warm(volt_warm_r),
        .volt_mid(volt_mid_r),
        .curr_warm(curr_warm_r),
        .curr_mid(curr_mid_r),
        .base_volt_code(base_volt_code),
        .base_curr_code(base_curr_code),
        .temp_region(temp_region),
        .region_volt_code(region_volt_code),
        .region_curr_code(region_curr_code)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_write_to(logic [7:0] c);
        wr_pulse && cmd_r == c;
    endsequence

    a_thr_four_write: assert property (s_write_to(CMD_THR_FOUR) |=> thr_four_r == $past(wr_data)) else $error("threshold four not written"); // [RULE1]
    a_thr_five_write: assert property (s_write_to(CMD_THR_FIVE) |=> thr_five_r == $past(wr_data)) else $error("threshold five not written"); // [RULE2]
    a_thr_six_write: assert property (s_write_to(CMD_THR_SIX) |=> thr_six_r == $past(wr_data)) else $error("threshold six not written"); // [RULE3]
    a_volt_warm_fields: assert property (s_write_to(CMD_VOLT_WARM) |=> volt_warm_r[9:5] == $past(wr_data[9:5]) && volt_warm_r[4:0] == $past(wr_data[4:0])) else $error("warm voltage fields wrong"); // [RULE5]
    a_volt_mid_fields: assert property (s_write_to(CMD_VOLT_MID) |=> volt_mid_r == $past(wr_data[14:0])) else $error("mid voltage fields wrong"); // [RULE7]
    a_curr_warm_fields: assert property (s_write_to(CMD_CURR_WARM) |=> curr_warm_r == $past(wr_data[9:0])) else $error("warm current fields wrong"); // [RULE11]
    a_curr_mid_fields: assert property (s_write_to(CMD_CURR_MID) |=> curr_mid_r == $past(wr_data[14:0])) else $error("mid current fields wrong"); // [RULE14]
    a_upper_bits_zero: assert property ((cmd_r == CMD_VOLT_WARM || cmd_r == CMD_CURR_WARM) |-> rd_word[15:10] == 6'h00) else $error("upper bits not zero"); // [RULE18]
    a_other_regs_hold: assert property (!wr_pulse |=> $stable(thr_four_r) && $stable(volt_mid_r) && $stable(curr_mid_r)) else $error("register changed without write"); // [RULE15]

endmodule // trcc_regs

/* File: trcc_pkg.sv */
package trcc_pkg;

    // Device address on the two-wire port; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a;

    // Command codes of the registers held here.
    localparam logic [7:0] CMD_THR_FOUR = 8'h22;
    localparam logic [7:0] CMD_THR_FIVE = 8'h23;
    localparam logic [7:0] CMD_THR_SIX = 8'h24;
    localparam logic [7:0] CMD_VOLT_WARM = 8'h25;
    localparam logic [7:0] CMD_VOLT_MID = 8'h26;
    localparam logic [7:0] CMD_CURR_WARM = 8'h27;
    localparam logic [7:0] CMD_CURR_MID = 8'h28;

    // Reset values of the registers.
    localparam logic [15:0] THR_FOUR_RST = 16'h1bc8;
    localparam logic [15:0] THR_FIVE_RST = 16'h18b5;
    localparam logic [15:0] THR_SIX_RST = 16'h136a;
    localparam logic [9:0] VOLT_WARM_RST = 10'h277;
    localparam logic [14:0] VOLT_MID_RST = 15'h5fff;
    localparam logic [9:0] CURR_WARM_RST = 10'h1ef;
    localparam logic [14:0] CURR_MID_RST = 15'h7fef;

    // Field layout: every code is five bits wide.
    localparam int CODE_W = 5;
    localparam int PAIR_W = 10;
    localparam int TRIO_W = 15;
    localparam int FLD_LO = 0;
    localparam int FLD_MID = 5;
    localparam int FLD_HI = 10;

    // Region numbering, coldest is one, warmest is seven.
    localparam int NUM_THR = 6;
    localparam logic [2:0] REGION_WARMEST = 3'h7;

    // Serial engine states, one-hot.
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_AACK = 9'h004,
        S_CMD = 9'h008,
        S_CACK = 9'h010,
        S_WR = 9'h020,
        S_WACK = 9'h040,
        S_RD = 9'h080,
        S_RACK = 9'h100
    } trcc_state_e;

endpackage

/* File: trcc_pin_events.sv */
`timescale 1ns/1ps
module trcc_pin_events
    import trcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det,
    output logic sda_val
);

    logic scl_q_r; // Current clock line sample.
    logic scl_d_r; // Previous clock line sample.
    logic sda_q_r; // Current data line sample.
    logic sda_d_r; // Previous data line sample.

    // Two samples of each line let us see edges; idle lines are high.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_q_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_q_r <= scl_in;
            scl_d_r <= scl_q_r;
            sda_q_r <= sda_in;
            sda_d_r <= sda_q_r;
        end
    end

    // A data edge while the clock stays high marks start or stop.
    assign scl_rise = scl_q_r & ~scl_d_r;
    assign scl_fall = ~scl_q_r & scl_d_r;
    assign start_det = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
    assign stop_det = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;
    assign sda_val = sda_q_r;

endmodule // trcc_pin_events

/* File: trcc_region_sel.sv */
`timescale 1ns/1ps
module trcc_region_sel
    import trcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic temp_qual_en,
    input wire logic [15:0] thermistor_reading,
    input wire logic [15:0] temp_threshold_one,
    input wire logic [15:0] temp_threshold_two,
    input wire logic [15:0] temp_threshold_three,
    input wire logic [15:0] temp_threshold_four,
    input wire logic [15:0] temp_threshold_five,
    input wire logic [15:0] temp_threshold_six,
    input wire logic [9:0] volt_warm,
    input wire logic [14:0] volt_mid,
    input wire logic [9:0] curr_warm,
    input wire logic [14:0] curr_mid,
    input wire logic [4:0] base_volt_code,
    input wire logic [4:0] base_curr_code,
    output logic [2:0] temp_region,
    output logic [4:0] region_volt_code,
    output logic [4:0] region_curr_code
);

    logic [15:0] thr [NUM_THR]; // Thresholds, coldest first.
    logic [NUM_THR-1:0] above; // Reading lies above each threshold.
    logic [2:0] region_nxt; // Region found this cycle.
    logic [4:0] volt_nxt; // Voltage code to present.
    logic [4:0] curr_nxt; // Current code to present.

    assign thr[0] = temp_threshold_one;
    assign thr[1] = temp_threshold_two;
    assign thr[2] = temp_threshold_three;
    assign thr[3] = temp_threshold_four;
    assign thr[4] = temp_threshold_five;
    assign thr[5] = temp_threshold_six;

    // The reading falls as it warms, so a colder boundary has a larger code.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_THR; gi++) begin : g_cmp
            assign above[gi] = $signed(thermistor_reading) > $signed(thr[gi]); // [RULE4]
        end
    endgenerate

    // Coldest boundary that the reading is above wins, which keeps the
    // result defined even when software writes misordered thresholds.
    always_comb begin
        region_nxt = REGION_WARMEST;
        for (int i = NUM_THR - 1; i >= 0; i--) begin
            if (above[i]) begin
                region_nxt = 3'(i + 1); // [RULE17]
            end
        end
    end

    // Codes pass unchanged; the charger applies the shared encodings.
    always_comb begin
        volt_nxt = base_volt_code;
        curr_nxt = base_curr_code;
        if (temp_qual_en) begin // [RULE16]
            unique case (region_nxt)
                3'h2: begin
                    volt_nxt = volt_mid[FLD_LO +: CODE_W]; // [RULE9] [RULE10]
                    curr_nxt = curr_mid[FLD_LO +: CODE_W]; // [RULE15] [RULE13]
                end
                3'h3: begin
                    volt_nxt = volt_mid[FLD_MID +: CODE_W]; // [RULE8]
                    curr_nxt = curr_mid[FLD_MID +: CODE_W]; // [RULE15]
                end
                3'h4: begin
                    volt_nxt = volt_mid[FLD_HI +: CODE_W]; // [RULE7]
                    curr_nxt = curr_mid[FLD_HI +: CODE_W]; // [RULE15]
                end
                3'h5: begin
                    volt_nxt = volt_warm[FLD_LO +: CODE_W]; // [RULE6]
                    curr_nxt = curr_warm[FLD_LO +: CODE_W]; // [RULE12]
                end
                3'h6: begin
                    volt_nxt = volt_warm[FLD_MID +: CODE_W]; // [RULE5]
                    curr_nxt = curr_warm[FLD_MID +: CODE_W]; // [RULE11]
                end
                // Regions one and seven pause charging; base codes stand.
                default: begin
                    volt_nxt = base_volt_code;
                    curr_nxt = base_curr_code;
                end
            endcase
        end
    end

    // Registered so the charger sees steady codes.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_region <= REGION_WARMEST;
            region_volt_code <= '0;
            region_curr_code <= '0;
        end else begin
            temp_region <= region_nxt;
            region_volt_code <= volt_nxt;
            region_curr_code <= curr_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_bypass_when_off: assert property (!temp_qual_en |=> region_volt_code == $past(base_volt_code) && region_curr_code == $past(base_curr_code)) else $error("base codes not passed while disabled"); // [RULE16]
    a_warmest_region: assert property ($signed(thermistor_reading) <= $signed(temp_threshold_six) && above == '0 |=> temp_region == REGION_WARMEST) else $error("warmest region not found"); // [RULE17]
    a_region_five_codes: assert property (temp_qual_en && above[4] && above[3:0] == 4'h0 |=> temp_region == 3'h5 && region_volt_code == $past(volt_warm[4:0]) && region_curr_code == $past(curr_warm[4:0])) else $error("region five codes wrong"); // [RULE6]

endmodule // trcc_region_sel

/* File: trcc_host.sv */
`timescale 1ns/1ps
// Host on the two-wire port. It drives the clock line and pulls data low.
module trcc_host
    import trcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Phases last five cycles, above the three-cycle floor.
    task automatic hp();
        repeat (5) @(posedge ref_clk);
    endtask
    // Start, also a repeated start when the clock is low.
    task automatic start();
        sda_low <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_low <= 1'b1;
        hp();
        scl <= 1'b0;
        hp();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_low <= 1'b0;
        hp();
    endtask
    // Nine clocks, most significant bit first. Data only moves while the clock is low.
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_low <= !d[i];
            hp();
            scl <= 1'b1;
            hp();
            q[i] = sda_line;
            scl <= 1'b0;
            hp();
        end
    endtask
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] w, output logic ok);
        logic [8:0] q [4];
        start();
        xfer({DEV_ADDR_DFLT, 2'b01}, q[0]);
        xfer({cmd, 1'b1}, q[1]);
        xfer({w[7:0], 1'b1}, q[2]);
        xfer({w[15:8], 1'b1}, q[3]);
        stop();
        ok = !(q[0][0] | q[1][0] | q[2][0] | q[3][0]);
    endtask
    // Low byte acked by the host, high byte refused to end the read.
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
        logic [8:0] q [4];
        start();
        xfer({DEV_ADDR_DFLT, 2'b01}, q[0]);
        xfer({cmd, 1'b1}, q[1]);
        start();
        xfer({DEV_ADDR_DFLT, 2'b11}, q[1]);
        xfer(9'h1fe, q[2]);
        xfer(9'h1ff, q[3]);
        stop();
        w = {q[3][8:1], q[2][8:1]};
    endtask
endmodule // trcc_host

/* File: tb_trcc.sv */
`timescale 1ns/1ps
// Register and region checks through the host model.
module testbench
    import trcc_pkg::*;
;
    logic ref_clk, arst_n, en, scl, h_low, ok;
    logic sda_oe, sda_o;
    logic [15:0] rdg, rd;
    logic [2:0] reg_n;
    logic [4:0] vc, cc;
    int fail_count = 0;
    int tests_run = 0;
    // Pulled-up data line, low when either side pulls.
    wire sda_w = !(h_low | (sda_oe & !sda_o));
    logic [15:0] rv [7] = '{THR_FOUR_RST, THR_FIVE_RST, THR_SIX_RST, 16'(VOLT_WARM_RST),
        16'(VOLT_MID_RST), 16'(CURR_WARM_RST), 16'(CURR_MID_RST)};
    // Writes to the narrow registers carry stray upper bits that must read back clear.
    logic [15:0] wp [7] = '{16'h1800, 16'h1000, 16'h0800, 16'hfcc5, 16'h9062, 16'hfdcd, 16'hb16a};
    logic [15:0] wx [7] = '{16'h1800, 16'h1000, 16'h0800, 16'h00c5, 16'h1062, 16'h01cd, 16'h316a};
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    trcc_host u_trcc_host (.ref_clk(ref_clk), .sda_line(sda_w), .scl(scl), .sda_low(h_low));
    trcc_regs u_trcc_regs (.ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe(sda_oe), .temp_qual_en(en), .thermistor_reading(rdg),
        .temp_threshold_one(16'h3000), .temp_threshold_two(16'h2800),
        .temp_threshold_three(16'h2000), .base_volt_code(5'h11), .base_curr_code(5'h01),
        .temp_region(reg_n), .region_volt_code(vc), .region_curr_code(cc));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog, so a hung port cannot stall the run.
    initial begin
        repeat (90000) @(posedge ref_clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        arst_n = 1'b0;
        en = 1'b1;
        rdg = 16'h0000;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 7; i++) begin
            u_trcc_host.read_word(CMD_THR_FOUR + 8'(i), rd);
            chk(rd, rv[i]);
            u_trcc_host.write_word(CMD_THR_FOUR + 8'(i), wp[i], ok);
            chk({15'h0, ok}, 16'h0001);
            u_trcc_host.read_word(CMD_THR_FOUR + 8'(i), rd);
            chk(rd, wx[i]);
        end
        // A command outside the bank is acked and reads as zero.
        u_trcc_host.read_word(CMD_CURR_MID + 8'h01, rd);
        chk(rd, 16'h0000);
        // Sweep all regions; the warmest reading is negative to prove a signed compare.
        for (int r = 1; r <= 7; r++) begin
            rdg <= (r == 7) ? 16'hff00 : 16'(32'h3801 - r * 32'h0800);
            repeat (3) @(posedge ref_clk);
            chk({13'h0, reg_n}, 16'(r));
            chk({11'h0, vc}, (r inside {1, 7}) ? 16'h0011 : 16'(r));
            chk({11'h0, cc}, (r inside {1, 7}) ? 16'h0001 : 16'(r + 8));
        end
        en <= 1'b0;
        rdg <= 16'h2001;
        repeat (3) @(posedge ref_clk);
        chk({6'h0, vc, cc}, 16'h0221);
        give_verdict();
    end
endmodule // testbench
